// *** logic/uisdc_event_ctrl.sv ***
`timescale 1ns/1ns
// ****************************************************************
// uart event status, clear, mask and dma request control
// ****************************************************************

// What this block does
// - A read-only raw status register at 0x3C shows each pending source: cts 1, rx 4, tx 5, timeout 6.
// - The raw register flags framing 7, parity 8, break 9 and overrun 10 as separate errors.
// - The raw register flags flow stop at 11 and tx fifo empty at 12, both zero after reset.
// - A read-only masked status register at 0x40 shows each source after its mask, same bits.
// - The masked register carries flow stop at bit 11 and tx fifo empty at bit 12.
// - A write-only clear register clears each source written with one and leaves zeros alone.
// - The clear register uses the same bit positions as the status registers.
// - A dma control register at 0x48, zero at reset, lets bit 0 enable receive dma requests.
// - Bit 1 of dma control enables transmit dma requests.
// - Bit 3 of dma control blocks receive dma requests while an error interrupt is asserted.
// - A mask register at 0x38 holds one read-back enable bit per source.
// - Transmit and receive events fire on 3-bit fifo fraction thresholds from 1/64 to 3/4.
module uisdc_event_ctrl
  import uisdc_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 64,
  parameter int unsigned CNT_W = $clog2(FIFO_DEPTH + 1)
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [DATA_W-1:0] pwdata_in,
  output logic [DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // event sources as one-cycle pulses, then fifo fill counts, from same-clock uart logic
  input wire logic cts_change_in,
  input wire logic rx_timeout_in,
  input wire logic framing_err_in,
  input wire logic parity_err_in,
  input wire logic break_err_in,
  input wire logic overrun_err_in,
  input wire logic flow_stop_in,
  input wire logic tx_fifo_empty_in,
  input wire logic [CNT_W-1:0] tx_count_in,
  input wire logic [CNT_W-1:0] rx_count_in,
  // dma side
  input wire logic rx_dma_need_in,
  input wire logic tx_dma_need_in,
  output logic rx_dma_req_out,
  output logic tx_dma_req_out,
  output logic irq_out
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [EV_W-1:0] raw_event_status_reg;
  logic [EV_W-1:0] raw_event_status_next;
  logic [EV_W-1:0] event_enable_mask_reg;
  logic [EV_W-1:0] event_enable_mask_next;
  logic [DMA_W-1:0] dma_request_control_reg;
  logic [DMA_W-1:0] dma_request_control_next;
  logic [LVL_W-1:0] level_select_reg;
  logic [LVL_W-1:0] level_select_next;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic read_raw_reg;
  logic irq_reg;
  logic rx_dma_req_reg;
  logic tx_dma_req_reg;

  logic transmit_raw;
  logic receive_raw;
  logic [EV_W-1:0] event_set;
  logic [EV_W-1:0] event_clr;
  logic [EV_W-1:0] masked_event_status;
  logic [EV_W-1:0] masked_next;
  logic err_irq_active;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic setup_phase;
  logic access_phase;
  logic wr_take;
  logic rd_take;
  logic addr_known;
  logic hit_level;
  logic hit_mask;
  logic hit_raw;
  logic hit_masked;
  logic hit_clear;
  logic hit_dma;

  // zero wait states: answer in the first access cycle while ce is high
  assign setup_phase = psel_in & ~penable_in & ce_in;
  assign access_phase = psel_in & penable_in & ce_in;
  assign wr_take = access_phase & pwrite_in;
  assign rd_take = access_phase & ~pwrite_in;
  assign hit_level = paddr_in == OFF_LEVEL_SEL;
  assign hit_mask = paddr_in == OFF_EVENT_MASK;
  assign hit_raw = paddr_in == OFF_RAW_STATUS;
  assign hit_masked = paddr_in == OFF_MASKED_STATUS;
  assign hit_clear = paddr_in == OFF_EVENT_CLEAR;
  assign hit_dma = paddr_in == OFF_DMA_CONTROL;
  assign addr_known = hit_level | hit_mask | hit_raw | hit_masked | hit_clear | hit_dma;

  // ****************************************************************
  // fifo thresholds
  // ****************************************************************
  uisdc_level_watch #(
    .DEPTH(FIFO_DEPTH),
    .CNT_W(CNT_W)
  ) u_level_watch (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .tx_count_in(tx_count_in),
    .rx_count_in(rx_count_in),
    .tx_sel_in(level_select_reg[LVL_TX_LSB +: LVL_SEL_W]),
    .rx_sel_in(level_select_reg[LVL_RX_LSB +: LVL_SEL_W]),
    .tx_cross_out(transmit_raw),
    .rx_cross_out(receive_raw)
  );

  // ****************************************************************
  // event capture
  // ****************************************************************
  // gather the sources into their status positions
  always_comb begin
    event_set = EVENT_RESET;
    event_set[BIT_CTS_CHANGE] = cts_change_in;
    event_set[BIT_RECEIVE] = receive_raw;
    event_set[BIT_TRANSMIT] = transmit_raw;
    event_set[BIT_RX_TIMEOUT] = rx_timeout_in;
    event_set[BIT_FRAMING_ERR] = framing_err_in;
    event_set[BIT_PARITY_ERR] = parity_err_in;
    event_set[BIT_BREAK_ERR] = break_err_in;
    event_set[BIT_OVERRUN_ERR] = overrun_err_in;
    event_set[BIT_FLOW_STOP] = flow_stop_in;
    event_set[BIT_TX_FIFO_EMPTY] = tx_fifo_empty_in;
  end

  // a read of raw status clears only the bits it returned, so an event
  // that lands between setup and access is kept for the next read
  assign event_clr = (wr_take & hit_clear) ? pwdata_in[EV_W-1:0]
                   : (rd_take & read_raw_reg) ? prdata_reg[EV_W-1:0]
                   : EVENT_RESET;

  // sticky bits; a set in the clearing cycle wins over the clear
  for (genvar i = 0; i < EV_W; i++) begin : g_sticky
    if (EVENT_VALID_MASK[i]) begin : g_used
      assign raw_event_status_next[i] = event_set[i] |
                                        (raw_event_status_reg[i] & ~event_clr[i]);
    end else begin : g_reserved
      assign raw_event_status_next[i] = 1'b0;
    end
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  assign event_enable_mask_next = (wr_take & hit_mask)
                                ? (pwdata_in[EV_W-1:0] & EVENT_VALID_MASK)
                                : event_enable_mask_reg;
  assign dma_request_control_next = (wr_take & hit_dma)
                                  ? (pwdata_in[DMA_W-1:0] & DMA_VALID_MASK)
                                  : dma_request_control_reg;
  assign level_select_next = (wr_take & hit_level) ? pwdata_in[LVL_W-1:0]
                           : level_select_reg;

  // masked view and the error term that can hold back receive dma
  assign masked_event_status = raw_event_status_reg & event_enable_mask_reg;
  assign masked_next = raw_event_status_next & event_enable_mask_next;
  assign err_irq_active = |(masked_event_status & EVENT_ERR_MASK);

  // ****************************************************************
  // read data, latched in the setup cycle
  // ****************************************************************
  // the clear register is write only and reads as zero
  assign prdata_next = hit_level ? {{(DATA_W - LVL_W){1'b0}}, level_select_reg}
                     : hit_mask ? {{(DATA_W - EV_W){1'b0}}, event_enable_mask_reg}
                     : hit_raw ? {{(DATA_W - EV_W){1'b0}}, raw_event_status_reg}
                     : hit_masked ? {{(DATA_W - EV_W){1'b0}}, masked_event_status}
                     : hit_dma ? {{(DATA_W - DMA_W){1'b0}}, dma_request_control_reg}
                     : READ_ZERO;
  assign pslverr_next = ~addr_known;

  // bus answer registers
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      prdata_reg <= READ_ZERO;
      pslverr_reg <= 1'b0;
      read_raw_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg <= pwrite_in ? READ_ZERO : prdata_next;
      pslverr_reg <= pslverr_next;
      read_raw_reg <= ~pwrite_in & hit_raw;
    end
  end

  // ****************************************************************
  // control and status registers
  // ****************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      raw_event_status_reg <= EVENT_RESET;
      event_enable_mask_reg <= EVENT_RESET;
      dma_request_control_reg <= DMA_RESET;
      level_select_reg <= LVL_RESET;
    end else if (ce_in) begin
      raw_event_status_reg <= raw_event_status_next;
      event_enable_mask_reg <= event_enable_mask_next;
      dma_request_control_reg <= dma_request_control_next;
      level_select_reg <= level_select_next;
    end
  end

  // ****************************************************************
  // interrupt and dma requests
  // ****************************************************************
  // registered from next values so irq tracks the status with no lag
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      irq_reg <= 1'b0;
      rx_dma_req_reg <= 1'b0;
      tx_dma_req_reg <= 1'b0;
    end else if (ce_in) begin
      irq_reg <= |masked_next;
      rx_dma_req_reg <= dma_request_control_reg[DMA_RX_EN_BIT] & rx_dma_need_in &
                        ~(dma_request_control_reg[DMA_BLOCK_ERR_BIT] & err_irq_active);
      tx_dma_req_reg <= dma_request_control_reg[DMA_TX_EN_BIT] & tx_dma_need_in;
    end
  end

  assign prdata_out = prdata_reg;
  assign pslverr_out = pslverr_reg & access_phase;
  assign pready_out = access_phase;
  assign irq_out = irq_reg;
  assign rx_dma_req_out = rx_dma_req_reg;
  assign tx_dma_req_out = tx_dma_req_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_cts_event_set: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && cts_change_in) |=> raw_event_status_reg[BIT_CTS_CHANGE])
    else $error("cts change did not set its status bit");

  a_error_flag_set: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && overrun_err_in && !framing_err_in) |=>
      raw_event_status_reg[BIT_OVERRUN_ERR] && !$rose(raw_event_status_reg[BIT_FRAMING_ERR]))
    else $error("overrun error not kept apart from framing");

  a_flow_stop_set: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && flow_stop_in) |=> raw_event_status_reg[BIT_FLOW_STOP])
    else $error("flow stop did not set its status bit");

  a_masked_read: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (setup_phase && !pwrite_in && hit_masked) |=>
      prdata_reg == {{(DATA_W - EV_W){1'b0}},
                     $past(raw_event_status_reg & event_enable_mask_reg)})
    else $error("masked status read returned wrong value");

  a_irq_from_masked: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    irq_reg == |(raw_event_status_reg & event_enable_mask_reg))
    else $error("interrupt output disagrees with masked status");

  a_masked_empty_bit: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (raw_event_status_reg[BIT_TX_FIFO_EMPTY] && event_enable_mask_reg[BIT_TX_FIFO_EMPTY])
      |-> masked_event_status[BIT_TX_FIFO_EMPTY] && irq_reg)
    else $error("masked tx fifo empty not raised");

  a_clear_drops_bit: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (wr_take && hit_clear && pwdata_in[BIT_CTS_CHANGE] && !cts_change_in)
      |=> !raw_event_status_reg[BIT_CTS_CHANGE])
    else $error("write one did not clear cts status");

  a_clear_keeps_bit: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (wr_take && hit_clear && !pwdata_in[BIT_RECEIVE] && raw_event_status_reg[BIT_RECEIVE])
      |=> raw_event_status_reg[BIT_RECEIVE])
    else $error("write zero disturbed receive status");

  a_rx_dma_gate: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    ce_in |=> rx_dma_req_reg == ($past(dma_request_control_reg[DMA_RX_EN_BIT]) &&
      $past(rx_dma_need_in) && !($past(dma_request_control_reg[DMA_BLOCK_ERR_BIT]) &&
      $past(err_irq_active))))
    else $error("receive dma request gating wrong");

  a_rx_dma_off: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && !dma_request_control_reg[DMA_RX_EN_BIT]) |=> !rx_dma_req_reg)
    else $error("receive dma request while disabled");

  a_tx_dma_gate: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    ce_in |=> tx_dma_req_reg == ($past(dma_request_control_reg[DMA_TX_EN_BIT]) &&
      $past(tx_dma_need_in)))
    else $error("transmit dma request gating wrong");

  a_mask_write: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (wr_take && hit_mask) |=> event_enable_mask_reg == ($past(pwdata_in[EV_W-1:0]) &
      EVENT_VALID_MASK))
    else $error("mask register did not take written value");

  a_reserved_zero: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    ((raw_event_status_reg & ~EVENT_VALID_MASK) == EVENT_RESET) &&
    ((dma_request_control_reg & ~DMA_VALID_MASK) == DMA_RESET))
    else $error("reserved bit became set");

endmodule

// *** inc/uisdc_pkg.sv ***
// ****************************************************************
// register map and field layout
// ****************************************************************
package uisdc_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned EV_W = 13;

  // register byte offsets
  localparam logic [7:0] OFF_LEVEL_SEL = 8'h34;
  localparam logic [7:0] OFF_EVENT_MASK = 8'h38;
  localparam logic [7:0] OFF_RAW_STATUS = 8'h3c;
  localparam logic [7:0] OFF_MASKED_STATUS = 8'h40;
  localparam logic [7:0] OFF_EVENT_CLEAR = 8'h44;
  localparam logic [7:0] OFF_DMA_CONTROL = 8'h48;

  // event bit positions, shared by raw, masked, mask and clear
  localparam int unsigned BIT_CTS_CHANGE = 1;
  localparam int unsigned BIT_RECEIVE = 4;
  localparam int unsigned BIT_TRANSMIT = 5;
  localparam int unsigned BIT_RX_TIMEOUT = 6;
  localparam int unsigned BIT_FRAMING_ERR = 7;
  localparam int unsigned BIT_PARITY_ERR = 8;
  localparam int unsigned BIT_BREAK_ERR = 9;
  localparam int unsigned BIT_OVERRUN_ERR = 10;
  localparam int unsigned BIT_FLOW_STOP = 11;
  localparam int unsigned BIT_TX_FIFO_EMPTY = 12;

  // implemented event bits and the four receive error bits
  localparam logic [EV_W-1:0] EVENT_VALID_MASK = 13'h1ff2;
  localparam logic [EV_W-1:0] EVENT_ERR_MASK = 13'h0780;
  localparam logic [EV_W-1:0] EVENT_RESET = 13'h0000;

  // dma control fields
  localparam int unsigned DMA_W = 4;
  localparam int unsigned DMA_RX_EN_BIT = 0;
  localparam int unsigned DMA_TX_EN_BIT = 1;
  localparam int unsigned DMA_BLOCK_ERR_BIT = 3;
  localparam logic [DMA_W-1:0] DMA_VALID_MASK = 4'hb;
  localparam logic [DMA_W-1:0] DMA_RESET = 4'h0;

  // fifo level select fields
  localparam int unsigned LVL_W = 6;
  localparam int unsigned LVL_TX_LSB = 0;
  localparam int unsigned LVL_RX_LSB = 3;
  localparam int unsigned LVL_SEL_W = 3;
  localparam logic [LVL_W-1:0] LVL_RESET = 6'h12;

  // level select codes, fraction of fifo depth
  localparam logic [2:0] SEL_1_64 = 3'h0;
  localparam logic [2:0] SEL_1_32 = 3'h1;
  localparam logic [2:0] SEL_1_16 = 3'h2;
  localparam logic [2:0] SEL_1_8 = 3'h3;
  localparam logic [2:0] SEL_1_4 = 3'h4;
  localparam logic [2:0] SEL_1_2 = 3'h5;
  localparam logic [2:0] SEL_3_4 = 3'h6;

  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

endpackage

// *** logic/uisdc_level_watch.sv ***
`timescale 1ns/1ns
// ****************************************************************
// fifo level threshold watcher
// ****************************************************************
module uisdc_level_watch
  import uisdc_pkg::*;
#(
  parameter int unsigned DEPTH = 64,
  parameter int unsigned CNT_W = $clog2(DEPTH + 1)
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic [CNT_W-1:0] tx_count_in,
  input wire logic [CNT_W-1:0] rx_count_in,
  input wire logic [LVL_SEL_W-1:0] tx_sel_in,
  input wire logic [LVL_SEL_W-1:0] rx_sel_in,
  output logic tx_cross_out,
  output logic rx_cross_out
);

  // the smallest fraction is 1/64, so shallower fifos cannot serve it;
  // the count must also reach a completely full fifo
  if (DEPTH < 64 || CNT_W < $clog2(DEPTH + 1)) begin : g_depth_check
    $error("uisdc_level_watch: DEPTH below 64 or CNT_W too narrow");
  end

  // entries that a select code stands for; unused code 7 never fires
  function automatic logic [CNT_W:0] frac_of(input logic [LVL_SEL_W-1:0] sel);
    logic [CNT_W:0] d;
    d = (CNT_W + 1)'(DEPTH);
    case (sel)
      SEL_1_64: frac_of = d >> 6;
      SEL_1_32: frac_of = d >> 5;
      SEL_1_16: frac_of = d >> 4;
      SEL_1_8: frac_of = d >> 3;
      SEL_1_4: frac_of = d >> 2;
      SEL_1_2: frac_of = d >> 1;
      SEL_3_4: frac_of = d - (d >> 2);
      default: frac_of = d + 1'b1;
    endcase
  endfunction

  logic [CNT_W:0] tx_free;
  logic tx_level;
  logic rx_level;
  logic tx_level_reg;
  logic rx_level_reg;
  logic tx_cross_reg;
  logic rx_cross_reg;

  // transmit counts emptiness, receive counts fullness
  assign tx_free = (CNT_W + 1)'(DEPTH) - {1'b0, tx_count_in};
  assign tx_level = tx_free >= frac_of(tx_sel_in);
  assign rx_level = {1'b0, rx_count_in} >= frac_of(rx_sel_in);

  // one pulse on each crossing, so a level that stays does not refire
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      tx_level_reg <= 1'b0;
      rx_level_reg <= 1'b0;
      tx_cross_reg <= 1'b0;
      rx_cross_reg <= 1'b0;
    end else if (ce_in) begin
      tx_level_reg <= tx_level;
      rx_level_reg <= rx_level;
      tx_cross_reg <= tx_level & ~tx_level_reg;
      rx_cross_reg <= rx_level & ~rx_level_reg;
    end
  end

  assign tx_cross_out = tx_cross_reg;
  assign rx_cross_out = rx_cross_reg;

  a_rx_level_cross: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && rx_level && !rx_level_reg) |=> rx_cross_reg)
    else $error("receive threshold crossing not flagged");

endmodule

// *** verification/uisdc_dma_model.sv ***
`timescale 1ns/1ns
// ****************************************************************
// dma side model: fifo fill levels in, need levels out
// ****************************************************************
module uisdc_dma_model
  import uisdc_pkg::*;
#(
  parameter int unsigned DEPTH = 64
) (
  input wire logic clk_sys_in,
  input wire logic [6:0] rx_count_in,
  input wire logic [6:0] tx_count_in,
  input wire logic rx_req_in,
  input wire logic tx_req_in,
  output logic rx_need_out,
  output logic tx_need_out,
  output int served_out
);
  // needs lag the levels a cycle, like a registered fifo flag
  always_ff @(posedge clk_sys_in) begin
    rx_need_out <= (rx_count_in != 7'h00);
    tx_need_out <= (32'(tx_count_in) < DEPTH);
    served_out <= served_out + int'(rx_req_in) + int'(tx_req_in);
  end
endmodule

// *** verification/uisdc_event_ctrl_tb_top.sv ***
`timescale 1ns/1ns
// ****************************************************************
// event status, clear, mask and dma bench
// ****************************************************************
module uisdc_event_ctrl_tb_top
  import uisdc_pkg::*;
;
  logic clk_sys_in, reset_in, ce, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, ev;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] rx_cnt, tx_cnt;
  logic rx_need, tx_need, rx_req, tx_req, irq;
  int served, failures, checked, raw_m, mask_m, dma_m, pw;
  int bpos[8] = '{1, 6, 7, 8, 9, 10, 11, 12};
  int thr[7] = '{1, 2, 4, 8, 16, 32, 48};

  uisdc_event_ctrl i_uisdc_event_ctrl (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .ce_in(ce), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .cts_change_in(ev[0]), .rx_timeout_in(ev[1]),
    .framing_err_in(ev[2]), .parity_err_in(ev[3]), .break_err_in(ev[4]),
    .overrun_err_in(ev[5]), .flow_stop_in(ev[6]), .tx_fifo_empty_in(ev[7]),
    .tx_count_in(tx_cnt), .rx_count_in(rx_cnt), .rx_dma_need_in(rx_need),
    .tx_dma_need_in(tx_need), .rx_dma_req_out(rx_req), .tx_dma_req_out(tx_req),
    .irq_out(irq));

  uisdc_dma_model i_uisdc_dma_model (.clk_sys_in(clk_sys_in), .rx_count_in(rx_cnt),
    .tx_count_in(tx_cnt), .rx_req_in(rx_req), .tx_req_in(tx_req),
    .rx_need_out(rx_need), .tx_need_out(tx_need), .served_out(served));

  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  task print_verdict;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; waits for pready under a bound
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n < 20) begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end else begin
      failures++;
      print_verdict();
    end
  endtask

  task wr(input logic [7:0] a, input int d);
    apb(1'b1, a, 32'(d));
  endtask

  task rdx(input logic [7:0] a, input int exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, 32'(exp));
  endtask

  // fill levels move together; crossing needs two edges to show
  task cnt(input int n);
    @(posedge clk_sys_in);
    rx_cnt <= 7'(n);
    tx_cnt <= 7'(64 - n);
    repeat (3) @(posedge clk_sys_in);
  endtask

  task check_pins;
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk(32'(irq), 32'((raw_m & mask_m) != 0));
    chk(32'(rx_req), 32'(dma_m[0] && rx_cnt != 0 &&
      !(dma_m[3] && (raw_m & mask_m & 32'h0000_0780) != 0)));
    chk(32'(tx_req), 32'(dma_m[1] && tx_cnt < 64));
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    failures = 0;
    checked = 0;
    raw_m = 0;
    mask_m = 0;
    dma_m = 0;
    reset_in = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ev = 8'h00;
    rx_cnt = 7'h00;
    tx_cnt = 7'h40;
    void'($urandom(2963));
    repeat (16) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    rdx(OFF_LEVEL_SEL, 32'h0000_0012);
    rdx(OFF_EVENT_MASK, 0);
    rdx(OFF_RAW_STATUS, 0);
    rdx(OFF_MASKED_STATUS, 0);
    rdx(OFF_DMA_CONTROL, 0);
    rdx(OFF_EVENT_CLEAR, 0);
    wr(OFF_DMA_CONTROL, 32'hffff_ffff);
    rdx(OFF_DMA_CONTROL, 32'h0000_000b);
    wr(OFF_EVENT_MASK, 32'hffff_ffff);
    rdx(OFF_EVENT_MASK, 32'h0000_1ff2);
    wr(OFF_EVENT_MASK, 0);
    wr(OFF_DMA_CONTROL, 0);
    apb(1'b0, 8'h4c, 32'h0000_0000);
    chk({rd[30:0], er}, 32'h0000_0001);
    // a pulse while the clock enable is low must leave no trace
    @(posedge clk_sys_in);
    ce <= 1'b0;
    ev <= 8'h01;
    @(posedge clk_sys_in);
    ev <= 8'h00;
    ce <= 1'b1;
    rdx(OFF_RAW_STATUS, 0);
    // every threshold code, just below and then at the level
    for (int c = 0; c < 7; c++) begin
      wr(OFF_LEVEL_SEL, c * 9);
      cnt(thr[c] - 1);
      rdx(OFF_RAW_STATUS, 0);
      cnt(thr[c]);
      // clear transmit only, so receive must survive a zero in its clear bit
      wr(OFF_EVENT_CLEAR, 32'h0000_0020);
      rdx(OFF_RAW_STATUS, 32'h0000_0010);
      cnt(0);
    end
    // code 7 parks both thresholds so random levels stay quiet
    wr(OFF_LEVEL_SEL, 32'h0000_003f);
    for (int k = 0; k < 16; k++) begin
      pw = $urandom;
      wr(OFF_EVENT_MASK, pw);
      mask_m = pw & 32'h0000_1ff2;
      pw = $urandom;
      wr(OFF_DMA_CONTROL, pw);
      dma_m = pw & 32'h0000_000b;
      rdx(OFF_DMA_CONTROL, dma_m);
      @(posedge clk_sys_in);
      ev <= 8'($urandom);
      rx_cnt <= 7'($urandom_range(0, 3));
      tx_cnt <= 7'($urandom_range(62, 64));
      @(posedge clk_sys_in);
      for (int i = 0; i < 8; i++) begin
        if (ev[i]) raw_m |= 1 << bpos[i];
      end
      ev <= 8'h00;
      check_pins();
      rdx(OFF_MASKED_STATUS, raw_m & mask_m);
      wr(OFF_RAW_STATUS, 32'hffff_ffff);
      if (k % 2 == 1) begin
        pw = $urandom;
        wr(OFF_EVENT_CLEAR, pw);
        raw_m = raw_m & ~pw;
      end
      rdx(OFF_RAW_STATUS, raw_m);
      raw_m = 0;
      check_pins();
    end
    // the dma side must have been served at least once by the random runs
    chk(32'(served != 0), 32'h0000_0001);
    print_verdict();
  end
endmodule
